// >>> design/dms_top.sv
// Debug match sequencer: comparators, priority logic and state sequencer
//
// Contract
// - Size check off: B matches like A/C
// - Size check on: only selected size matches
// - Only the exact stored address matches
// - Range uses A data and A read/write
// - Range uses A tag and A breakpoint
// - Range with tags resolves to words
// - Inside range needs both in cycle
// - Outside range accepts either comparator
// - Forced match steps sequencer and flags
// - Tag on fetch, step on tag hit
// - Force trigger enters Final, breakpoint, trace
// - Priority: trigger, match0, match1, match2
// - Match leading to Final wins, except a match2 suppressed by a range match
// - Range plus C match: match0 wins
// - Arm gives state1; Final exits to state0
// - Each transition updates state flags
// - Breakpoint-on-match channel breaks immediately
// - Breakpoint match passes Final one cycle
// - Final without trace: break, disarm
// - Final with trace: trigger, end disarms
// - Comparators idle in host debug mode
// - Untagged compares bus; tagged ignores qualifiers
`timescale 1ns/1ps
`default_nettype none
module dms_top
  import dms_pkg::*;
(
  input  wire logic              I_CLOCK,       // Bus clock
  input  wire logic              I_RESET_N,     // System reset, active low
  input  wire logic [3:0]        I_REG_ADDR,    // Register index
  input  wire logic [17:0]       I_REG_WDATA,   // Register write data
  input  wire logic              I_REG_WR,      // Write strobe
  input  wire logic              I_REG_RD,      // Read strobe
  input  wire logic              I_BUS_VALID,   // CPU bus cycle present
  input  wire logic [ADDR_W-1:0] I_BUS_ADDR,    // CPU address
  input  wire logic [DATA_W-1:0] I_BUS_DATA,    // CPU data
  input  wire logic              I_BUS_READ,    // 1 read, 0 write
  input  wire logic              I_BUS_BYTE,    // 1 byte, 0 word access
  input  wire logic              I_BUS_FETCH,   // Opcode fetch cycle
  input  wire logic [2:0]        I_TAG_HIT,     // Tag hit per channel from CPU
  input  wire logic              I_HOST_DEBUG,  // host_debug_mode active
  input  wire logic              I_TRACE_DONE,  // Trace session completed
  output logic [17:0]            O_REG_RDATA,   // Read data, cycle after strobe
  output logic                   O_BREAK_REQ,   // Breakpoint request pulse
  output logic                   O_FORCED_BRK,  // Forced breakpoint request pulse
  output logic [2:0]             O_TAG_SET,     // Tag request on fetch per channel
  output logic                   O_TRACE_FORCE_TRIGGER,  // Trigger pulse to trace buffer
  output logic                   O_TRACE_ALIGN, // Trigger alignment to trace buffer
  output logic                   O_ARMED        // Session active
);

  // Reset release synchroniser
  logic rst_meta_ff;  // First stage
  logic rst_n_ff;     // Released reset used by the design

  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // Configuration registers
  logic [7:0]        ctl_ff [3];   // Control of comparators A, B, C
  logic [ADDR_W-1:0] addr_ff [3];  // Stored addresses
  logic [DATA_W-1:0] data_a_ff;    // Comparator A data
  logic [DATA_W-1:0] mask_a_ff;    // Comparator A data mask
  logic [1:0]        range_ff;     // debug_control_two range code
  logic [11:0]       scc_ff;       // state_control_code, 3 bits per state 1..3 plus spare
  logic [1:0]        trace_ff;     // Trace source and alignment
  logic              arm_ff;       // Armed, session active
  logic              force_trigger_ff;      // Force trigger pending
  dms_state_t        state_ff;     // Sequencer state
  logic [2:0]        ssf_ff;       // sequencer_state_flags
  logic              fin_brk_ff;   // Final was entered by a breakpoint match, or forced without trace

  // Write decoding
  function automatic logic wr_hit(input logic [3:0] ofs);
    wr_hit = I_REG_WR && (I_REG_ADDR == ofs);
  endfunction

  // Configuration writes; arm is cleared by the sequencer when disarming
  always_ff @(posedge I_CLOCK or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      for (int i = 0; i < 3; i++)
      begin
        ctl_ff[i]  <= CTL_RST;
        addr_ff[i] <= ADDR_RST;
      end
      data_a_ff <= DATA_RST;
      mask_a_ff <= DATA_RST;
      range_ff  <= RANGE_OFF;
      scc_ff    <= SCC_RST;
      trace_ff  <= 2'h0;
    end
    else
    begin
      if (wr_hit(OFS_COMP_A)) ctl_ff[0] <= I_REG_WDATA[7:0];
      if (wr_hit(OFS_COMP_B)) ctl_ff[1] <= I_REG_WDATA[7:0];
      if (wr_hit(OFS_COMP_C)) ctl_ff[2] <= I_REG_WDATA[7:0];
      if (wr_hit(OFS_ADDR_A)) addr_ff[0] <= I_REG_WDATA;
      if (wr_hit(OFS_ADDR_B)) addr_ff[1] <= I_REG_WDATA;
      if (wr_hit(OFS_ADDR_C)) addr_ff[2] <= I_REG_WDATA;
      if (wr_hit(OFS_DATA_A)) data_a_ff <= I_REG_WDATA[15:0];
      if (wr_hit(OFS_MASK_A)) mask_a_ff <= I_REG_WDATA[15:0];
      if (wr_hit(OFS_CTRL_TWO)) range_ff <= I_REG_WDATA[1:0];
      if (wr_hit(OFS_STATE_CTL)) scc_ff <= I_REG_WDATA[11:0];
      if (wr_hit(OFS_TRACE)) trace_ff <= I_REG_WDATA[1:0];
    end
  end

  // Qualification of one comparator against the current bus cycle
  function automatic logic qual(input logic [7:0] ctl, input logic sz_ok);
    logic rw_ok;
    rw_ok = !ctl[CT_RWE] || (ctl[CT_RW] == I_BUS_READ);
    qual  = rw_ok && sz_ok;
  endfunction

  // Comparator hits and range logic
  logic       host_ok;     // Comparators live only outside host debug
  logic       rng_on;      // Range mode active
  logic       lo_hit;      // Address above A
  logic       hi_hit;      // Address below B
  logic       rng_hit;     // Range address condition
  logic       data_ok;     // Comparator A data condition
  logic [2:0] exact;       // Exact address equality per channel
  logic [2:0] force_m;     // Forced matches per match channel
  logic [2:0] tag_m;       // Tagged channel select
  logic [2:0] brk_sel;     // Breakpoint-on-match per match channel
  logic [ADDR_W-1:0] cmp_addr; // Address seen by range compare

  always_comb
  begin
    host_ok = I_BUS_VALID && !I_HOST_DEBUG;
    rng_on  = range_ff != RANGE_OFF;
    data_ok = ((I_BUS_DATA ^ data_a_ff) & mask_a_ff) == DATA_RST;
    // Word resolution for tagged ranges: drop the byte bit
    cmp_addr = I_BUS_ADDR;
    if (ctl_ff[0][CT_TAG])
      cmp_addr[0] = 1'b0;
    // Aligned address decides a straddling word
    lo_hit = cmp_addr > addr_ff[0];
    hi_hit = cmp_addr < addr_ff[1];
    if (range_ff == RANGE_INSIDE)
      rng_hit = lo_hit && hi_hit;
    else
      rng_hit = (cmp_addr < addr_ff[0]) || (cmp_addr > addr_ff[1]);
    for (int i = 0; i < 3; i++)
      exact[i] = I_BUS_ADDR == addr_ff[i];
    // Range uses A's qualifiers, data and tag
    force_m[0] = host_ok && ctl_ff[0][CT_ENABLE] && !ctl_ff[0][CT_TAG] &&
                 (rng_on ? rng_hit : exact[0]) && qual(ctl_ff[0], 1'b1) && data_ok;
    // Size qualification on B
    force_m[1] = host_ok && !rng_on && ctl_ff[1][CT_ENABLE] && !ctl_ff[1][CT_TAG] &&
                 exact[1] &&
                 qual(ctl_ff[1], !ctl_ff[1][CT_SZE] || (ctl_ff[1][CT_SZ] == I_BUS_BYTE));
    force_m[2] = host_ok && ctl_ff[2][CT_ENABLE] && !ctl_ff[2][CT_TAG] &&
                 exact[2] && qual(ctl_ff[2], 1'b1);
    // Tag selection ignores qualifiers
    tag_m[0] = host_ok && I_BUS_FETCH && ctl_ff[0][CT_ENABLE] && ctl_ff[0][CT_TAG] &&
               (rng_on ? rng_hit : exact[0]);
    tag_m[1] = host_ok && I_BUS_FETCH && !rng_on && ctl_ff[1][CT_ENABLE] &&
               ctl_ff[1][CT_TAG] && exact[1];
    tag_m[2] = host_ok && I_BUS_FETCH && ctl_ff[2][CT_ENABLE] && ctl_ff[2][CT_TAG] &&
               exact[2];
    brk_sel = {ctl_ff[2][CT_BRK], ctl_ff[1][CT_BRK] && !rng_on, ctl_ff[0][CT_BRK]};
  end

  // Forced matches registered once; tag hits come later from the CPU
  logic [2:0] force_q_ff;  // Registered forced matches
  logic [2:0] tag_q_ff;    // Registered tag hits
  logic [2:0] tag_set_ff;  // Tag requests toward the instruction queue

  always_ff @(posedge I_CLOCK or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      force_q_ff <= 3'h0;
      tag_q_ff   <= 3'h0;
      tag_set_ff <= 3'h0;
    end
    else
    begin
      force_q_ff <= force_m;
      tag_q_ff   <= I_TAG_HIT & {ctl_ff[2][CT_TAG], !rng_on && ctl_ff[1][CT_TAG],
                                 ctl_ff[0][CT_TAG]} & {3{!I_HOST_DEBUG}};
      tag_set_ff <= tag_m;
    end
  end

  // Channel events, with range suppression of match2
  logic [2:0] ev;          // Events per channel
  logic [2:0] nxt_code [3];// Next state code per channel
  logic [2:0] code_cur;    // state_control_code of current state
  logic       ev_win_ok;   // Some event selected
  logic [2:0] win_code;    // Selected next state code
  logic       win_brk;     // Winner has breakpoint-on-match

  // Next code for a channel event from the current state's control
  function automatic logic [2:0] code_of(input logic [2:0] sc, input int ch);
    code_of = sc[ch] ? SSF_FN : (sc == 3'h0 ? SSF_S0 : (ch == 0 ? SSF_S2 :
              (ch == 1 ? SSF_S3 : SSF_S1)));
  endfunction

  always_comb
  begin
    ev = force_q_ff | tag_q_ff;
    if (rng_on && ev[0])
      ev[2] = 1'b0;
    case (state_ff)
      ST_ONE:   code_cur = scc_ff[2:0];
      ST_TWO:   code_cur = scc_ff[5:3];
      ST_THREE: code_cur = scc_ff[8:6];
      default:  code_cur = 3'h0;
    endcase
    for (int i = 0; i < 3; i++)
      nxt_code[i] = code_of(code_cur, i);
    ev_win_ok = 1'b0;
    win_code  = SSF_S0;
    win_brk   = 1'b0;
    // Final-bound matches first then lowest channel
    for (int i = 2; i >= 0; i--)
      if (ev[i] && !(ev_win_ok && win_code == SSF_FN && nxt_code[i] != SSF_FN))
      begin
        ev_win_ok = 1'b1;
        win_code  = nxt_code[i];
        win_brk   = brk_sel[i];
      end
    for (int i = 2; i >= 0; i--)
      if (ev[i] && nxt_code[i] == SSF_FN)
      begin
        win_code = SSF_FN;
        win_brk  = brk_sel[i];
      end
  end

  // Sequencer with arm and force trigger
  logic force_trigger_wr;   // Software force trigger write
  logic arm_wr;    // Software arm write
  logic trace_run_ff;  // Trace session running after Final

  assign force_trigger_wr = wr_hit(OFS_CTRL_ONE) && I_REG_WDATA[C1_FORCE_TRIGGER];
  assign arm_wr  = wr_hit(OFS_CTRL_ONE);

  always_ff @(posedge I_CLOCK or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      state_ff     <= ST_IDLE;
      ssf_ff       <= SSF_S0;
      arm_ff       <= 1'b0;
      force_trigger_ff      <= 1'b0;
      fin_brk_ff   <= 1'b0;
      trace_run_ff <= 1'b0;
    end
    else
    begin
      force_trigger_ff <= 1'b0;
      if (force_trigger_wr)
      begin
        // Immediate trigger wins over everything
        state_ff   <= ST_FINAL;
        ssf_ff     <= SSF_FN;
        arm_ff     <= 1'b1;
        force_trigger_ff    <= 1'b1;
        // With trace on, Final holds until the session ends
        fin_brk_ff <= !trace_ff[TR_SRC];
      end
      else if (arm_wr && !I_REG_WDATA[C1_ARM])
      begin
        state_ff <= ST_IDLE;
        ssf_ff   <= SSF_S0;
        arm_ff   <= 1'b0;
        trace_run_ff <= 1'b0;
      end
      else if (arm_wr && state_ff == ST_IDLE)
      begin
        state_ff <= ST_ONE;
        ssf_ff   <= SSF_S1;
        arm_ff   <= 1'b1;
      end
      else
        case (state_ff)
          ST_ONE, ST_TWO, ST_THREE:
          begin
            if (ev_win_ok)
            begin
              ssf_ff <= win_code;
              case (win_code)
                SSF_S1:  state_ff <= ST_ONE;
                SSF_S2:  state_ff <= ST_TWO;
                SSF_S3:  state_ff <= ST_THREE;
                SSF_FN:  state_ff <= ST_FINAL;
                default: state_ff <= state_ff;
              endcase
              if (win_code == SSF_S0)
              begin
                ssf_ff   <= ssf_ff;
              end
              fin_brk_ff <= win_brk;
            end
          end
          ST_FINAL:
          begin
            // Breakpoint end or no trace: one cycle then state0
            if (fin_brk_ff || !trace_ff[TR_SRC] || (trace_run_ff && I_TRACE_DONE))
            begin
              state_ff     <= ST_IDLE;
              ssf_ff       <= SSF_S0;
              arm_ff       <= 1'b0;
              trace_run_ff <= 1'b0;
            end
            else
              trace_run_ff <= 1'b1;
          end
          default:
          begin
            state_ff <= ST_IDLE;  // Disarmed ignores matches
            ssf_ff   <= SSF_S0;
          end
        endcase
    end
  end

  // Breakpoint, trace trigger and read data outputs
  always_ff @(posedge I_CLOCK or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      O_BREAK_REQ   <= 1'b0;
      O_FORCED_BRK  <= 1'b0;
      O_TAG_SET     <= 3'h0;
      O_TRACE_FORCE_TRIGGER  <= 1'b0;
      O_TRACE_ALIGN <= 1'b0;
      O_ARMED       <= 1'b0;
      O_REG_RDATA   <= 18'h00000;
    end
    else
    begin
      // Immediate channel breakpoints, even when disarmed
      O_BREAK_REQ  <= |(ev & brk_sel) ||
                      (state_ff == ST_FINAL && trace_ff[TR_SRC] && trace_run_ff &&
                       I_TRACE_DONE);
      O_FORCED_BRK <= force_trigger_ff || (state_ff == ST_FINAL && !trace_ff[TR_SRC] &&
                      !fin_brk_ff);
      O_TAG_SET    <= tag_set_ff;
      // Trace trigger once on entering Final
      O_TRACE_FORCE_TRIGGER <= state_ff == ST_FINAL && !trace_run_ff && trace_ff[TR_SRC];
      O_TRACE_ALIGN <= trace_ff[TR_ALIGN];
      O_ARMED      <= arm_ff;
      O_REG_RDATA  <= 18'h00000;
      if (I_REG_RD)
        case (I_REG_ADDR)
          OFS_CTRL_ONE:  O_REG_RDATA <= {10'h000, arm_ff, 7'h00};
          OFS_CTRL_TWO:  O_REG_RDATA <= {16'h0000, range_ff};
          OFS_COMP_A:    O_REG_RDATA <= {10'h000, ctl_ff[0]};
          OFS_COMP_B:    O_REG_RDATA <= {10'h000, ctl_ff[1]};
          OFS_COMP_C:    O_REG_RDATA <= {10'h000, ctl_ff[2]};
          OFS_ADDR_A:    O_REG_RDATA <= addr_ff[0];
          OFS_ADDR_B:    O_REG_RDATA <= addr_ff[1];
          OFS_ADDR_C:    O_REG_RDATA <= addr_ff[2];
          OFS_DATA_A:    O_REG_RDATA <= {2'h0, data_a_ff};
          OFS_MASK_A:    O_REG_RDATA <= {2'h0, mask_a_ff};
          OFS_STATE_CTL: O_REG_RDATA <= {6'h00, scc_ff};
          OFS_TRACE:     O_REG_RDATA <= {16'h0000, trace_ff};
          OFS_STATUS:    O_REG_RDATA <= {15'h0000, ssf_ff};
          default:       O_REG_RDATA <= 18'h00000;
        endcase
    end
  end

  // Forced match reaches the sequencer two cycles after the bus cycle
  AST_FORCE_STEP: assert property (@(posedge I_CLOCK) disable iff (!rst_n_ff)
    (force_m[0] && !rng_on && state_ff == ST_ONE && !I_REG_WR && !I_HOST_DEBUG)
      |=> ##1 (state_ff != ST_ONE || $past(code_cur) == 3'h0 ||
               $past(nxt_code[0]) == SSF_S1))
    else $error("Forced match did not step sequencer");

  AST_FORCE_TRIGGER_FINAL: assert property (@(posedge I_CLOCK) disable iff (!rst_n_ff)
    force_trigger_wr |=> (state_ff == ST_FINAL && ssf_ff == SSF_FN) ##1 O_FORCED_BRK)
    else $error("Force trigger did not reach Final with break");

  AST_ARM_ONE: assert property (@(posedge I_CLOCK) disable iff (!rst_n_ff)
    (arm_wr && I_REG_WDATA[C1_ARM] && !force_trigger_wr && state_ff == ST_IDLE)
      |=> state_ff == ST_ONE && ssf_ff == SSF_S1)
    else $error("Arm did not enter state1");

  AST_FINAL_EXIT: assert property (@(posedge I_CLOCK) disable iff (!rst_n_ff)
    (state_ff == ST_FINAL && !force_trigger_wr && !arm_wr) |=> state_ff inside {ST_FINAL, ST_IDLE})
    else $error("Final left to a state other than state0");

  AST_BRK_FINAL: assert property (@(posedge I_CLOCK) disable iff (!rst_n_ff)
    (state_ff == ST_FINAL && fin_brk_ff && !force_trigger_wr && !arm_wr) |=> state_ff == ST_IDLE)
    else $error("Breakpoint end stayed in Final");

  AST_NO_TRACE: assert property (@(posedge I_CLOCK) disable iff (!rst_n_ff)
    (state_ff == ST_FINAL && !trace_ff[TR_SRC] && !force_trigger_wr && !arm_wr) |=> !arm_ff)
    else $error("Final without trace did not disarm");

  AST_HOST_QUIET: assert property (@(posedge I_CLOCK) disable iff (!rst_n_ff)
    I_HOST_DEBUG |-> force_m == 3'h0 && tag_m == 3'h0)
    else $error("Comparator active in host debug mode");

  AST_SIZE_B: assert property (@(posedge I_CLOCK) disable iff (!rst_n_ff)
    (ctl_ff[1][CT_SZE] && ctl_ff[1][CT_SZ] != I_BUS_BYTE) |-> !force_m[1])
    else $error("Comparator B matched wrong size");

  AST_RANGE_C: assert property (@(posedge I_CLOCK) disable iff (!rst_n_ff)
    (rng_on && force_q_ff[0]) |-> !ev[2])
    else $error("Match2 not suppressed by range match");

  AST_FLAGS: assert property (@(posedge I_CLOCK) disable iff (!rst_n_ff)
    (state_ff == ST_IDLE) == (ssf_ff == SSF_S0))
    else $error("State flags disagree with sequencer");

endmodule
`default_nettype wire

// >>> design/dms_pkg.sv
// Package with constants and types for the debug match sequencer
package dms_pkg;

  // Widths of the watched buses
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 16;

  // Register offsets on the plain register port
  localparam logic [3:0] OFS_CTRL_ONE  = 4'h0;  // debug_control_one: arm, force trigger
  localparam logic [3:0] OFS_CTRL_TWO  = 4'h1;  // debug_control_two: range mode
  localparam logic [3:0] OFS_COMP_A    = 4'h2;  // comp_a_control_reg
  localparam logic [3:0] OFS_COMP_B    = 4'h3;  // comp_b_control_reg
  localparam logic [3:0] OFS_COMP_C    = 4'h4;  // comp_c control
  localparam logic [3:0] OFS_ADDR_A    = 4'h5;
  localparam logic [3:0] OFS_ADDR_B    = 4'h6;
  localparam logic [3:0] OFS_ADDR_C    = 4'h7;
  localparam logic [3:0] OFS_DATA_A    = 4'h8;  // Comparator A data
  localparam logic [3:0] OFS_MASK_A    = 4'h9;  // Comparator A data mask
  localparam logic [3:0] OFS_STATE_CTL = 4'hA;  // state_control_code per state
  localparam logic [3:0] OFS_TRACE     = 4'hB;  // trace_source_enable, trigger_align_select
  localparam logic [3:0] OFS_STATUS    = 4'hC;  // debug_status_reg (read only)

  // debug_control_one bits
  localparam int unsigned C1_ARM  = 7;
  localparam int unsigned C1_FORCE_TRIGGER = 6;

  // debug_control_two range code
  localparam logic [1:0] RANGE_OFF     = 2'h0;
  localparam logic [1:0] RANGE_INSIDE  = 2'h2;
  localparam logic [1:0] RANGE_OUTSIDE = 2'h3;

  // Comparator control bits
  localparam int unsigned CT_ENABLE = 0;  // comp enable
  localparam int unsigned CT_BRK    = 1;  // breakpoint_on_match
  localparam int unsigned CT_TAG    = 2;
  localparam int unsigned CT_RWE    = 3;  // read_write_check_enable
  localparam int unsigned CT_RW     = 4;  // 1 selects read
  localparam int unsigned CT_SZE    = 5;  // size_check_enable
  localparam int unsigned CT_SZ     = 6;  // size_select: 1 byte, 0 word

  // Trace register bits
  localparam int unsigned TR_SRC   = 0;
  localparam int unsigned TR_ALIGN = 1;

  // Reset values
  localparam logic [7:0]        CTL_RST  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [11:0]       SCC_RST  = 12'h000;

  // Flag codes of the sequencer (3 bits)
  localparam logic [2:0] SSF_S0 = 3'h0;
  localparam logic [2:0] SSF_S1 = 3'h1;
  localparam logic [2:0] SSF_S2 = 3'h2;
  localparam logic [2:0] SSF_S3 = 3'h3;
  localparam logic [2:0] SSF_FN = 3'h4;

  // Sequencer state, one hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_ONE   = 5'b00010,
    ST_TWO   = 5'b00100,
    ST_THREE = 5'b01000,
    ST_FINAL = 5'b10000
  } dms_state_t;

endpackage

// >>> sim/dms_cpu_model.sv
// CPU side model: bus cycles and tag hits at execution
`timescale 1ns/1ps
`default_nettype none
module dms_cpu_model
  import dms_pkg::*;
(
  input  wire logic              i_clk,     // Bus clock
  input  wire logic [2:0]        i_tag_set, // Tag request on fetch
  output logic                   o_valid,   // Bus cycle present
  output logic [ADDR_W-1:0]      o_addr,    // Address
  output logic [DATA_W-1:0]      o_data,    // Data
  output logic                   o_read,    // 1 read
  output logic                   o_byte,    // 1 byte
  output logic                   o_fetch,   // Opcode fetch
  output logic [2:0]             o_tag_hit  // Tag hit at execution
);
  logic [2:0] q1_ff; // Tagged opcode in queue
  logic [2:0] q2_ff; // Tagged opcode near execution
  initial
  begin
    {o_valid, o_read, o_byte, o_fetch} = 4'h0;
    o_addr = 18'h00000;
    o_data = 16'h0000;
  end
  // Tags reach execution three cycles after the tag request
  always @(posedge i_clk)
  begin
    q1_ff     <= i_tag_set;
    q2_ff     <= q1_ff;
    o_tag_hit <= q2_ff;
  end
  // One bus cycle; on release address and data show inverted values
  task automatic cycle(input logic [17:0] a, input logic b, input logic f);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_addr  <= a;
    o_byte  <= b;
    o_fetch <= f;
    o_read  <= 1'b1;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_addr  <= ~a;
    o_data  <= ~o_data;
  endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the debug match sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dms_pkg::*;
  logic        clk, rst_n, wr, rd, hdbg, tdone; // Bench driven
  logic [3:0]  ra;                              // Register index
  logic [17:0] wd, rdata;                       // Register data
  logic        v, rdb, byt, fet, breakpoint_on_match, fbrk, ttrig, trigger_align_select, armed;
  logic [17:0] ba;                              // Bus address
  logic [15:0] bd;                              // Bus data
  logic [2:0]  tset, thit;                      // Tag lines
  logic        sb, sf, stt, stg;                // Seen pulses
  int          failures = 0;
  int          tests_run = 0;
  dms_cpu_model u_cpu (.i_clk(clk), .i_tag_set(tset), .o_valid(v),
    .o_addr(ba), .o_data(bd), .o_read(rdb), .o_byte(byt), .o_fetch(fet),
    .o_tag_hit(thit));
  dms_top u_dut (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_REG_ADDR(ra),
    .I_REG_WDATA(wd), .I_REG_WR(wr), .I_REG_RD(rd), .I_BUS_VALID(v),
    .I_BUS_ADDR(ba), .I_BUS_DATA(bd), .I_BUS_READ(rdb), .I_BUS_BYTE(byt),
    .I_BUS_FETCH(fet), .I_TAG_HIT(thit), .I_HOST_DEBUG(hdbg),
    .I_TRACE_DONE(tdone), .O_REG_RDATA(rdata), .O_BREAK_REQ(breakpoint_on_match),
    .O_FORCED_BRK(fbrk), .O_TAG_SET(tset), .O_TRACE_FORCE_TRIGGER(ttrig),
    .O_TRACE_ALIGN(trigger_align_select), .O_ARMED(armed));
  // Clock, 10 ns period
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Register write, one strobe cycle
  task automatic wreg(input logic [3:0] a, input logic [17:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read state flags and compare
  task automatic st(input logic [2:0] e);
    @(posedge clk);
    ra <= OFS_STATUS;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, {15'h0000, e});
  endtask
  // Watch output pulses for n cycles
  task automatic watch(input int n);
    {sb, sf, stt, stg} = 4'h0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      sb |= breakpoint_on_match;
      sf |= fbrk;
      stt |= ttrig;
      stg |= |tset;
    end
  endtask
  // One bus cycle, then watch
  task automatic bus(input logic [17:0] a, input logic b, input logic f);
    u_cpu.cycle(a, b, f);
    watch(10);
  endtask
  // Size qualification of comparator B
  task automatic t_size;
    wreg(OFS_ADDR_B, 18'h00100);
    for (int i = 0; i < 8; i++)
    begin
      wreg(OFS_COMP_B, {11'h000, i[1], i[2], 5'h03});
      bus(18'h00100, i[0], 1'b0);
      chk(sb, !i[2] || (i[1] == i[0]));
    end
    wreg(OFS_COMP_B, 18'h00000);
  endtask
  // Inside and outside range, host debug mode
  task automatic t_range;
    wreg(OFS_ADDR_A, 18'h00100);
    wreg(OFS_ADDR_B, 18'h00200);
    wreg(OFS_COMP_A, 18'h00003);
    wreg(OFS_COMP_B, 18'h00001);
    wreg(OFS_CTRL_TWO, {16'h0000, RANGE_INSIDE});
    bus(18'h00150, 1'b0, 1'b0);
    chk(sb, 1'b1);
    bus(18'h00250, 1'b0, 1'b0);
    chk(sb, 1'b0);
    wreg(OFS_ADDR_B, 18'h3FFFF);
    wreg(OFS_CTRL_TWO, {16'h0000, RANGE_OUTSIDE});
    bus(18'h00050, 1'b0, 1'b0);
    chk(sb, 1'b1);
    bus(18'h00150, 1'b0, 1'b0);
    chk(sb, 1'b0);
    bus(18'h00100, 1'b0, 1'b0);
    chk(sb, 1'b0);
    bus(18'h3FFF0, 1'b0, 1'b0);
    chk(sb, 1'b0);
    hdbg <= 1'b1;
    bus(18'h00050, 1'b0, 1'b0);
    chk(sb, 1'b0);
    hdbg <= 1'b0;
    wreg(OFS_CTRL_TWO, 18'h00000);
  endtask
  // Range match beats a simultaneous comparator C match
  task automatic t_rngc;
    wreg(OFS_ADDR_B, 18'h00200);
    wreg(OFS_ADDR_C, 18'h00150);
    wreg(OFS_COMP_C, 18'h00001);
    wreg(OFS_STATE_CTL, 18'h00004);
    wreg(OFS_CTRL_TWO, {16'h0000, RANGE_INSIDE});
    wreg(OFS_CTRL_ONE, 18'h00080);
    bus(18'h00150, 1'b0, 1'b0);
    st(SSF_S2);
    wreg(OFS_CTRL_ONE, 18'h00000);
    wreg(OFS_COMP_C, 18'h00000);
    wreg(OFS_CTRL_TWO, 18'h00000);
  endtask
  // Sequencer walk with simultaneous A and B matches
  task automatic t_seq;
    wreg(OFS_COMP_A, 18'h00001);
    wreg(OFS_ADDR_B, 18'h00100);
    wreg(OFS_STATE_CTL, 18'h00014);
    bus(18'h00100, 1'b0, 1'b0);
    st(SSF_S0);
    wreg(OFS_CTRL_ONE, 18'h00080);
    st(SSF_S1);
    bus(18'h000FF, 1'b0, 1'b0);
    st(SSF_S1);
    bus(18'h00100, 1'b0, 1'b0);
    st(SSF_S2);
    bus(18'h00100, 1'b0, 1'b0);
    chk(sf, 1'b1);
    st(SSF_S0);
    chk(armed, 1'b0);
  endtask
  // Tagged fetch on comparator C
  task automatic t_tag;
    wreg(OFS_COMP_A, 18'h00000);
    wreg(OFS_COMP_B, 18'h00000);
    wreg(OFS_ADDR_C, 18'h00120);
    wreg(OFS_COMP_C, 18'h00005);
    wreg(OFS_STATE_CTL, 18'h00004);
    wreg(OFS_CTRL_ONE, 18'h00080);
    bus(18'h00120, 1'b0, 1'b1);
    chk(stg, 1'b1);
    chk(sf, 1'b1);
    st(SSF_S0);
  endtask
  // Force trigger without and with tracing
  task automatic t_force_trigger;
    wreg(OFS_CTRL_ONE, 18'h000C0);
    watch(6);
    chk(sf, 1'b1);
    st(SSF_S0);
    wreg(OFS_TRACE, 18'h00003);
    wreg(OFS_CTRL_ONE, 18'h000C0);
    watch(4);
    chk({stt, trigger_align_select}, 2'h3);
    st(SSF_FN);
    @(posedge clk);
    tdone <= 1'b1;
    watch(1);
    tdone <= 1'b0;
    chk(sb, 1'b1);
    watch(4);
    chk({sb, armed}, 2'h0);
  endtask
  // Verdict
  task automatic end_of_test;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #50000;
    failures++;
    end_of_test();
  end
  // Main sequence
  initial
  begin
    {rst_n, wr, rd, hdbg, tdone} = 5'h0;
    ra = 4'h0;
    wd = 18'h00000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    st(SSF_S0);
    t_size();
    t_range();
    t_rngc();
    t_seq();
    t_tag();
    t_force_trigger();
    end_of_test();
  end
endmodule
`default_nettype wire
